// [hw/adcs_pkg.sv]
package adcs_pkg;

    // ****************************************
    // register byte addresses (one word each)
    // ****************************************
    localparam logic [7:0] addr_control_one = 8'h00;
    localparam logic [7:0] addr_control_two = 8'h04;
    localparam logic [7:0] addr_result_high = 8'h08;
    localparam logic [7:0] addr_result_low = 8'h0c;
    localparam logic [7:0] addr_irq_control = 8'h10;

    // ****************************************
    // control one fields
    // ****************************************
    localparam int chan_lsb = 0; // external_channel_select [3:0]
    localparam int power_bit = 5; // converter_power_enable
    localparam int format_bit = 6; // result_format_select
    localparam int start_bit = 7; // start
    localparam int busy_bit = 8; // conversion_busy_flag, read only

    // ****************************************
    // control two fields
    // ****************************************
    localparam int div_lsb = 0; // conv_clock_divider [2:0]
    localparam int ref_lsb = 3; // reference_source_select [1:0]
    localparam int src_lsb = 5; // input_source_select [2:0]

    // ****************************************
    // interrupt control fields
    // ****************************************
    localparam int gie_bit = 0; // global_interrupt_enable
    localparam int mfie_bit = 1; // multifunction_interrupt_enable
    localparam int cie_bit = 2; // converter_interrupt_enable
    localparam int req_bit = 3; // converter_interrupt_request

    // ****************************************
    // reset values and conversion timing
    // ****************************************
    localparam logic [3:0] chan_reset = 4'h0;
    localparam logic [2:0] div_reset = 3'h0;
    localparam logic [1:0] ref_reset = 2'h0;
    localparam logic [2:0] src_reset = 3'h0;
    localparam logic [4:0] sample_periods = 5'h04;
    localparam logic [4:0] total_periods = 5'h10;
    localparam int result_width = 12;
    localparam logic [11:0] full_scale = 12'hfff;
    localparam logic [2:0] src_external = 3'h0;
    localparam logic [3:0] chan_count = 4'h3; // codes 0..2 are pins

    typedef enum logic [2:0] {
        adcs_idle = 3'b001,
        adcs_sample = 3'b010,
        adcs_convert = 3'b100
    } adcs_state_e;

endpackage

// [hw/adcs_clock_divider.sv]
// ****************************************
// converter clock enable from power-of-two divider
// ****************************************
module adcs_clock_divider (
    input wire logic sys_clk, // system clock
    input wire logic srst, // synchronous reset, high
    input wire logic run, // divider runs while high
    input wire logic [2:0] div_code, // 0 -> /1 .. 7 -> /128
    output logic tick // one-cycle converter clock enable
);
    logic [6:0] count;
    logic [6:0] limit;

    // limit is 2^code - 1; code 0 gives a tick every cycle
    assign limit = 7'((8'h01 << div_code) - 8'h01);

    // free count restarts when stopped so the first period is whole
    always_ff @(posedge sys_clk) begin
        if (srst || !run) begin
            count <= 7'h00;
            tick <= 1'b0;
        end else if (count >= limit) begin
            count <= 7'h00;
            tick <= 1'b1;
        end else begin
            count <= count + 7'h01;
            tick <= 1'b0;
        end
    end
endmodule // adcs_clock_divider

// [hw/adcs_sequencer.sv]
// Design decisions made here: the APB interface to the registers and the register offsets.
module adcs_sequencer (
    input wire logic sys_clk, // system clock, 40 MHz
    input wire logic srst, // synchronous reset, high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic [11:0] core_data, // result from analog core
    output logic conv_power_on, // analog core power
    output logic core_sample, // core sampling phase
    output logic core_convert, // core conversion phase
    output logic [3:0] pin_select, // routed external pin
    output logic [2:0] internal_select, // routed internal source, 0 none
    output logic [1:0] reference_select, // reference source to core
    output logic converter_irq // interrupt to cpu
);
    // ****************************************
    // registers
    // ****************************************
    logic [3:0] external_channel_select;
    logic converter_power_enable;
    logic result_format_select;
    logic start;
    logic start_prev;
    logic [2:0] conv_clock_divider;
    logic [1:0] reference_source_select;
    logic [2:0] input_source_select;
    logic global_interrupt_enable;
    logic multifunction_interrupt_enable;
    logic converter_interrupt_enable;
    logic converter_interrupt_request;
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;
    adcs_pkg::adcs_state_e state;
    logic [4:0] periods;
    logic tick;
    logic done;
    logic launch;
    logic wr_en;
    logic rd_en;
    logic mapped;
    logic [31:0] next_prdata;

    // ****************************************
    // bus decode
    // ****************************************
    // writes land only at the ready edge; reads are taken at setup so the
    // data already stands when the master samples ready
    assign wr_en = psel && penable && pwrite && pready;
    assign rd_en = psel && !penable && !pwrite;

    // one decode for the error flag, so a new register is added in one place
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == adcs_pkg::addr_control_one) || (a == adcs_pkg::addr_control_two)
            || (a == adcs_pkg::addr_result_high) || (a == adcs_pkg::addr_result_low)
            || (a == adcs_pkg::addr_irq_control);
    endfunction

    assign mapped = is_mapped(paddr);

    // the error flag rises with ready, so a refused access still completes
    // no wait states: ready rises in the first access cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
        end
    end

    // read data latched at setup; busy and flags are live at that cycle
    always_comb begin
        next_prdata = 32'h0000_0000;
        unique case (paddr)
            adcs_pkg::addr_control_one: begin
                next_prdata[adcs_pkg::chan_lsb +: 4] = external_channel_select;
                next_prdata[adcs_pkg::power_bit] = converter_power_enable;
                next_prdata[adcs_pkg::format_bit] = result_format_select;
                next_prdata[adcs_pkg::start_bit] = start;
                next_prdata[adcs_pkg::busy_bit] = (state != adcs_pkg::adcs_idle);
            end
            adcs_pkg::addr_control_two: begin
                next_prdata[adcs_pkg::div_lsb +: 3] = conv_clock_divider;
                next_prdata[adcs_pkg::ref_lsb +: 2] = reference_source_select;
                next_prdata[adcs_pkg::src_lsb +: 3] = input_source_select;
            end
            adcs_pkg::addr_result_high: next_prdata[7:0] = result_high_byte;
            adcs_pkg::addr_result_low: next_prdata[7:0] = result_low_byte;
            adcs_pkg::addr_irq_control: begin
                next_prdata[adcs_pkg::gie_bit] = global_interrupt_enable;
                next_prdata[adcs_pkg::mfie_bit] = multifunction_interrupt_enable;
                next_prdata[adcs_pkg::cie_bit] = converter_interrupt_enable;
                next_prdata[adcs_pkg::req_bit] = converter_interrupt_request;
            end
            default: next_prdata = 32'h0000_0000;
        endcase
    end

    // read data holds between reads; a write leaves it untouched
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= next_prdata;
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    // first control word: channel, power, format and start; start is plain
    // storage and the sequencer below watches its falling edge
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            external_channel_select <= adcs_pkg::chan_reset;
            converter_power_enable <= 1'b0;
            result_format_select <= 1'b0;
            start <= 1'b0;
        end else if (wr_en && paddr == adcs_pkg::addr_control_one) begin
            external_channel_select <= pwdata[adcs_pkg::chan_lsb +: 4];
            converter_power_enable <= pwdata[adcs_pkg::power_bit];
            result_format_select <= pwdata[adcs_pkg::format_bit];
            start <= pwdata[adcs_pkg::start_bit];
        end
    end

    // second control word: divider, reference and source; a change while
    // converting acts at once, so software should change it only when idle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            conv_clock_divider <= adcs_pkg::div_reset;
            reference_source_select <= adcs_pkg::ref_reset;
            input_source_select <= adcs_pkg::src_reset;
        end else if (wr_en && paddr == adcs_pkg::addr_control_two) begin
            conv_clock_divider <= pwdata[adcs_pkg::div_lsb +: 3];
            reference_source_select <= pwdata[adcs_pkg::ref_lsb +: 2];
            input_source_select <= pwdata[adcs_pkg::src_lsb +: 3];
        end
    end

    // interrupt word: three enables and the request flag
    // enables are plain storage; software writes 0 to the request to clear it
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            global_interrupt_enable <= 1'b0;
            multifunction_interrupt_enable <= 1'b0;
            converter_interrupt_enable <= 1'b0;
        end else if (wr_en && paddr == adcs_pkg::addr_irq_control) begin
            global_interrupt_enable <= pwdata[adcs_pkg::gie_bit];
            multifunction_interrupt_enable <= pwdata[adcs_pkg::mfie_bit];
            converter_interrupt_enable <= pwdata[adcs_pkg::cie_bit];
        end
    end

    // completion wins over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            converter_interrupt_request <= 1'b0;
        end else if (done) begin
            converter_interrupt_request <= 1'b1;
        end else if (wr_en && paddr == adcs_pkg::addr_irq_control) begin
            converter_interrupt_request <= pwdata[adcs_pkg::req_bit];
        end
    end

    // ****************************************
    // conversion sequencer
    // ****************************************
    // divider runs only from launch to completion, saving toggles when idle;
    // its count restarts for each conversion
    adcs_clock_divider u_div (
        .sys_clk(sys_clk),
        .srst(srst),
        .run(state != adcs_pkg::adcs_idle || launch),
        .div_code(conv_clock_divider),
        .tick(tick)
    );

    // completion is the last converter tick of the conversion phase
    assign done = (state == adcs_pkg::adcs_convert) && tick
        && (periods == adcs_pkg::total_periods - 5'h01);

    // a launch also starts the divider, so the first period is whole and
    // sampling lasts four periods, not one system cycle more
    assign launch = converter_power_enable && start_prev && !start;

    // falling start edge, after a high, launches; a new start restarts a running one
    // a start held high keeps the sequencer idle, which doubles as a reset
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            start_prev <= 1'b0;
        end else begin
            start_prev <= start;
        end
    end

    // phase sequencer: periods counts converter ticks across both phases,
    // so the phase change and completion share one counter; power removal
    // wins over everything and aborts a conversion
    always_ff @(posedge sys_clk) begin
        if (srst || !converter_power_enable) begin
            state <= adcs_pkg::adcs_idle;
            periods <= 5'h00;
        end else if (start) begin
            state <= adcs_pkg::adcs_idle;
            periods <= 5'h00;
        end else if (launch) begin
            state <= adcs_pkg::adcs_sample;
            periods <= 5'h00;
        end else if (tick) begin
            periods <= periods + 5'h01;
            // idle and any stray code fall to the default and stay idle
            unique case (state)
                adcs_pkg::adcs_sample: begin
                    if (periods == adcs_pkg::sample_periods - 5'h01) begin
                        state <= adcs_pkg::adcs_convert;
                    end
                end
                adcs_pkg::adcs_convert: begin
                    if (done) begin
                        state <= adcs_pkg::adcs_idle;
                    end
                end
                default: state <= adcs_pkg::adcs_idle;
            endcase
        end
    end

    // capture only on completion so the last result stays put
    // the core code passes unscaled: one code is one reference step
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            result_high_byte <= 8'h00;
            result_low_byte <= 8'h00;
        end else if (done) begin
            if (result_format_select) begin
                result_high_byte <= {4'h0, core_data[11:8]};
                result_low_byte <= core_data[7:0];
            end else begin
                result_high_byte <= core_data[11:4];
                result_low_byte <= {core_data[3:0], 4'h0};
            end
        end
    end

    // ****************************************
    // analog side
    // ****************************************
    // every output here is registered, so the core sees clean levels
    // an internal source is only routed when the pin code is parked, so a
    // careless order cannot short a pin onto the internal node
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            conv_power_on <= 1'b0;
            core_sample <= 1'b0;
            core_convert <= 1'b0;
            pin_select <= adcs_pkg::chan_reset;
            internal_select <= adcs_pkg::src_reset;
            reference_select <= adcs_pkg::ref_reset;
            converter_irq <= 1'b0;
        end else begin
            conv_power_on <= converter_power_enable;
            core_sample <= state == adcs_pkg::adcs_sample;
            core_convert <= state == adcs_pkg::adcs_convert;
            pin_select <= (input_source_select == adcs_pkg::src_external)
                ? external_channel_select : adcs_pkg::chan_count;
            internal_select <= (input_source_select != adcs_pkg::src_external
                && external_channel_select >= adcs_pkg::chan_count)
                ? input_source_select : adcs_pkg::src_external;
            reference_select <= reference_source_select;
            converter_irq <= converter_interrupt_request && converter_interrupt_enable
                && multifunction_interrupt_enable && global_interrupt_enable;
        end
    end
endmodule // adcs_sequencer

// [dv/adcs_sequencer_asserts.sv]
// ********************
// port-level checker
// ********************
module adcs_sequencer_checker (
    input wire logic sys_clk, // clock
    input wire logic srst, // reset
    input wire logic psel, // select
    input wire logic penable, // enable
    input wire logic pwrite, // direction
    input wire logic [7:0] paddr, // address
    input wire logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic [11:0] core_data, // result in
    input wire logic conv_power_on, // power
    input wire logic core_sample, // sampling
    input wire logic core_convert, // converting
    input wire logic [3:0] pin_select, // pin
    input wire logic [2:0] internal_select, // internal
    input wire logic [1:0] reference_select, // reference
    input wire logic converter_irq // irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // a write lands at the ready edge; outputs follow two edges on
    logic commit;
    logic mapped;
    assign commit = psel && penable && pready && pwrite;
    assign mapped = paddr inside {adcs_pkg::addr_control_one, adcs_pkg::addr_control_two,
        adcs_pkg::addr_result_high, adcs_pkg::addr_result_low, adcs_pkg::addr_irq_control};

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_err_on_unmapped: assert property (psel && !penable && !mapped |=> pslverr)
        else $error("unmapped access not refused");
    a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    a_power_follows: assert property (
        commit && paddr == adcs_pkg::addr_control_one
        |-> ##2 conv_power_on == $past(pwdata[adcs_pkg::power_bit], 2))
        else $error("power output wrong");
    a_ref_follows: assert property (
        commit && paddr == adcs_pkg::addr_control_two
        |-> ##2 reference_select == $past(pwdata[4:3], 2))
        else $error("reference output wrong");
    a_power_off_idle: assert property (
        $fell(conv_power_on) |=> !core_sample && !core_convert)
        else $error("phases run unpowered");
    a_phase_exclusive: assert property (!(core_sample && core_convert))
        else $error("both phases high");
    a_sample_first: assert property (
        $rose(core_convert) |-> $past(core_sample) && !core_sample)
        else $error("convert without sample");
    a_sample_powered: assert property ($rose(core_sample) |-> conv_power_on)
        else $error("sample while off");
    a_internal_parked: assert property (internal_select != 3'h0 |-> pin_select == 4'h3)
        else $error("pin not parked");

    c_conv_done: cover property ($fell(core_convert));
    c_refused: cover property (pslverr);
    c_irq: cover property ($rose(converter_irq));
endmodule // adcs_sequencer_checker

bind adcs_sequencer adcs_sequencer_checker adcs_sequencer_checker_i (
    .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_data(core_data), .conv_power_on(conv_power_on), .core_sample(core_sample),
    .core_convert(core_convert), .pin_select(pin_select), .internal_select(internal_select),
    .reference_select(reference_select), .converter_irq(converter_irq));

// [dv/adcs_sequencer_tb.sv]
// ********************
// sequencer testbench
// ********************
module adcs_sequencer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [11:0] core_data = 12'h000;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, rerr, conv_power_on, core_sample, core_convert, converter_irq;
    logic [3:0] pin_select;
    logic [2:0] internal_select;
    logic [1:0] reference_select;
    int num_errors = 0;
    int num_checks = 0;
    int conv_len = 0;
    int samp_len = 0;

    adcs_sequencer adcs_sequencer_i (.sys_clk(sys_clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_data(core_data),
        .conv_power_on(conv_power_on), .core_sample(core_sample),
        .core_convert(core_convert), .pin_select(pin_select),
        .internal_select(internal_select), .reference_select(reference_select),
        .converter_irq(converter_irq));

    always #12.5 sys_clk = ~sys_clk;
    // free-running tally, so a test takes the difference and never clears it
    always @(posedge sys_clk) if (core_convert === 1'b1) conv_len <= conv_len + 1;
    always @(posedge sys_clk) if (core_sample === 1'b1) samp_len <= samp_len + 1;

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer; request held until ready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) chk("pready", 32'(pready), 32'h1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic test_regs;
        logic [7:0] ad [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
        foreach (ad[i]) begin
            xfer(1'b0, ad[i], 32'h0);
            chk("reset value", rdata, 32'h0);
        end
        xfer(1'b1, 8'h14, 32'hffffffff);
        xfer(1'b0, 8'h14, 32'h0);
        chk("unmapped err", 32'(rerr), 32'h1);
        chk("unmapped data", rdata, 32'h0);
        xfer(1'b1, adcs_pkg::addr_control_two, 32'hff);
        xfer(1'b0, adcs_pkg::addr_control_two, 32'h0);
        chk("ctl2 readback", rdata, 32'hff);
        xfer(1'b1, adcs_pkg::addr_control_one, 32'h100);
        xfer(1'b0, adcs_pkg::addr_control_one, 32'h0);
        chk("busy read only", rdata, 32'h0);
        $display("test_regs done");
    endtask

    task automatic test_route;
        xfer(1'b1, adcs_pkg::addr_control_two, 32'h18);
        xfer(1'b1, adcs_pkg::addr_control_one, 32'h22);
        repeat (2) @(posedge sys_clk);
        chk("pin", 32'(pin_select), 32'h2);
        chk("internal", 32'(internal_select), 32'h0);
        chk("reference", 32'(reference_select), 32'h3);
        chk("power on", 32'(conv_power_on), 32'h1);
        xfer(1'b1, adcs_pkg::addr_control_one, 32'h23);
        xfer(1'b1, adcs_pkg::addr_control_two, 32'h20);
        repeat (2) @(posedge sys_clk);
        chk("parked pin", 32'(pin_select), 32'h3);
        chk("internal src", 32'(internal_select), 32'h1);
        xfer(1'b1, adcs_pkg::addr_control_one, 32'h0);
        repeat (2) @(posedge sys_clk);
        chk("power off", 32'(conv_power_on), 32'h0);
        $display("test_route done");
    endtask

    task automatic run_conv(input logic [2:0] dv, input logic fmt, input logic [11:0] v);
        int c0;
        int s0;
        int n;
        logic [7:0] hi, lo;
        hi = fmt ? {4'h0, v[11:8]} : v[11:4];
        lo = fmt ? v[7:0] : {v[3:0], 4'h0};
        n = 0;
        core_data <= v;
        xfer(1'b1, adcs_pkg::addr_control_two, 32'(dv));
        xfer(1'b1, adcs_pkg::addr_control_one, 32'h0a0 | (32'(fmt) << 6));
        c0 = conv_len;
        s0 = samp_len;
        xfer(1'b1, adcs_pkg::addr_control_one, 32'h020 | (32'(fmt) << 6));
        repeat (3) @(posedge sys_clk);
        xfer(1'b0, adcs_pkg::addr_control_one, 32'h0);
        chk("busy high", 32'(rdata[8]), 32'h1);
        while (rdata[8] !== 1'b0 && n < 1000) begin
            xfer(1'b0, adcs_pkg::addr_control_one, 32'h0);
            n++;
        end
        chk("busy low", 32'(rdata[8]), 32'h0);
        chk("sample len", 32'(samp_len - s0), 32'(4 << dv));
        chk("convert len", 32'(conv_len - c0), 32'(12 << dv));
        xfer(1'b0, adcs_pkg::addr_result_high, 32'h0);
        chk("result high", rdata, 32'(hi));
        xfer(1'b0, adcs_pkg::addr_result_low, 32'h0);
        chk("result low", rdata, 32'(lo));
        core_data <= ~v;
        xfer(1'b0, adcs_pkg::addr_result_high, 32'h0);
        chk("result held", rdata, 32'(hi));
    endtask

    task automatic test_conv;
        run_conv(3'h0, 1'b1, adcs_pkg::full_scale);
        run_conv(3'h2, 1'b0, 12'ha5c);
        run_conv(3'h7, 1'b1, 12'h123);
        $display("test_conv done");
    endtask

    task automatic test_irq;
        xfer(1'b1, adcs_pkg::addr_irq_control, 32'h7);
        run_conv(3'h1, 1'b0, 12'h800);
        repeat (2) @(posedge sys_clk);
        chk("irq raised", 32'(converter_irq), 32'h1);
        xfer(1'b0, adcs_pkg::addr_irq_control, 32'h0);
        chk("request set", rdata, 32'hf);
        xfer(1'b1, adcs_pkg::addr_irq_control, 32'he);
        repeat (2) @(posedge sys_clk);
        chk("irq masked", 32'(converter_irq), 32'h0);
        xfer(1'b1, adcs_pkg::addr_irq_control, 32'h7);
        xfer(1'b0, adcs_pkg::addr_irq_control, 32'h0);
        chk("request clear", rdata, 32'h7);
        $display("test_irq done");
    endtask

    // power removed mid-conversion aborts it; result and request stay put
    task automatic test_abort;
        core_data <= 12'h5a5;
        xfer(1'b1, adcs_pkg::addr_control_two, 32'h3);
        xfer(1'b1, adcs_pkg::addr_control_one, 32'h0a0);
        xfer(1'b1, adcs_pkg::addr_control_one, 32'h020);
        repeat (40) @(posedge sys_clk);
        xfer(1'b0, adcs_pkg::addr_control_one, 32'h0);
        chk("abort running", 32'(rdata[8]), 32'h1);
        xfer(1'b1, adcs_pkg::addr_control_one, 32'h000);
        // phase outputs trail the state by one cycle, hence three edges
        repeat (3) @(posedge sys_clk);
        chk("abort phases", 32'({core_sample, core_convert}), 32'h0);
        xfer(1'b0, adcs_pkg::addr_control_one, 32'h0);
        chk("abort busy", 32'(rdata[8]), 32'h0);
        repeat (200) @(posedge sys_clk);
        // last completed result is 12'h800 left aligned, from test_irq
        xfer(1'b0, adcs_pkg::addr_result_high, 32'h0);
        chk("abort result", rdata, 32'h80);
        xfer(1'b0, adcs_pkg::addr_irq_control, 32'h0);
        chk("abort request", rdata, 32'h7);
        $display("test_abort done");
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ********************
    // main sequence and watchdog
    // ********************
    initial begin
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        test_regs;
        test_route;
        test_conv;
        test_irq;
        test_abort;
        report_and_stop;
    end

    // slowest conversion is about 2k cycles; the limit leaves ample margin
    initial begin
        repeat (30000) @(posedge sys_clk);
        num_errors++;
        report_and_stop;
    end
endmodule // adcs_sequencer_tb
